//--- fetch_fault_pkg.sv
// Constants, register map and state type for the instruction fetch fault unit.
// Assumes a 32-bit core with bits numbered 0 (msb) to 31 (lsb) in its state words.
package fetch_fault_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_RETURN = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MSTATE = 8'h08;
  localparam logic [7:0] OFS_EVENT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // State word fields, as lsb index of the big-endian bit number
  localparam int unsigned POS_DOZE = 31 - 13;
  localparam int unsigned POS_HANDLER_ORDER = 31 - 15;
  localparam int unsigned POS_IRQ_ENABLE = 31 - 16;
  localparam int unsigned POS_USER = 31 - 17;
  localparam int unsigned POS_FLOAT = 31 - 18;
  localparam int unsigned POS_MCHECK = 31 - 19;
  localparam int unsigned POS_FEXC_A = 31 - 20;
  localparam int unsigned POS_STEP = 31 - 21;
  localparam int unsigned POS_BTRACE = 31 - 22;
  localparam int unsigned POS_FEXC_B = 31 - 23;
  localparam int unsigned POS_VEC_SEL = 31 - 25;
  localparam int unsigned POS_IRELOC = 31 - 26;
  localparam int unsigned POS_DRELOC = 31 - 27;
  localparam int unsigned POS_RECOVER = 31 - 30;
  localparam int unsigned POS_BYTE_ORDER = 31 - 31;

  // Saved status cause fields
  localparam int unsigned POS_CAUSE_MISS = 31 - 1;
  localparam int unsigned POS_CAUSE_STORAGE = 31 - 3;
  localparam int unsigned POS_CAUSE_PROT = 31 - 4;

  // Bits 16-23, 25-27, 30-31 copied; bits 10-15 fall outside and read zero
  localparam logic [31:0] COPY_MASK = 32'h0000_ff73;
  // Bits cleared on entry
  localparam logic [31:0] CLEAR_MASK = (32'h1 << POS_DOZE) | (32'h1 << POS_IRQ_ENABLE)
    | (32'h1 << POS_USER) | (32'h1 << POS_FLOAT) | (32'h1 << POS_FEXC_A)
    | (32'h1 << POS_STEP) | (32'h1 << POS_BTRACE) | (32'h1 << POS_FEXC_B)
    | (32'h1 << POS_IRELOC) | (32'h1 << POS_DRELOC) | (32'h1 << POS_RECOVER)
    | (32'h1 << POS_BYTE_ORDER);

  // Vector placement
  localparam logic [31:0] VEC_OFFSET = 32'h0000_0400;
  localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH = 32'hfff0_0000;

  // Event bits: one per cause class
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_MISS = 0;
  localparam int unsigned EVT_STORAGE = 1;
  localparam int unsigned EVT_PROT = 2;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

  // Whole state of the unit
  typedef struct packed {
    logic [31:0] ret;
    logic [31:0] status;
    logic [31:0] mstate;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic [31:0] rdata;
    logic ack;
    logic redirect;
    logic [31:0] target;
    logic irq;
  } unit_state_t;
endpackage

//--- fetch_fault_if.sv
// Bundle between the fault unit and its cause classifier.
// Assumes both ends sit in one clock domain; purely combinational signals.
`timescale 1ns/10ps
`default_nettype none
interface fetch_fault_if;
  logic xlate_miss;
  logic noexec_seg;
  logic guarded;
  logic prot_denied;
  logic direct_store;
  logic relocate_on;
  logic [2:0] cause;
  logic fault;

  modport classifier (
    input xlate_miss, noexec_seg, guarded, prot_denied, direct_store, relocate_on,
    output cause, fault
  );
  modport core (
    output xlate_miss, noexec_seg, guarded, prot_denied, direct_store, relocate_on,
    input cause, fault
  );
endinterface // fetch_fault_if
`default_nettype wire

//--- fetch_fault_classifier.sv
// Cause classifier: turns raw fetch failure flags into one cause class.
// Assumes flags are valid in the same cycle as the fetch they describe.
`timescale 1ns/10ps
`default_nettype none
module fetch_fault_classifier (
  fetch_fault_if.classifier ff
);
  import fetch_fault_pkg::*;

  logic storage;

  // Segment class failures: guarded only counts with relocation on
  always_comb begin
    storage = ff.direct_store | ff.noexec_seg | (ff.guarded & ff.relocate_on);
  end

  // One class only: segment first, then missing translation, then protection
  always_comb begin
    ff.cause = 3'h0;
    ff.cause[EVT_STORAGE] = storage;
    ff.cause[EVT_MISS] = ff.xlate_miss & ~storage;
    ff.cause[EVT_PROT] = ff.prot_denied & ~storage & ~ff.xlate_miss;
    ff.fault = |ff.cause;
  end
endmodule // fetch_fault_classifier
`default_nettype wire

//--- fetch_fault_unit.sv
// Instruction fetch fault unit: takes the fault, saves state, redirects the core.
// Assumes a classic Wishbone master and a fetch path that presents one result a cycle.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module fetch_fault_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_next_ea,
  input wire logic fetch_branch,
  input wire logic [31:0] fetch_branch_ea,
  input wire logic xlate_miss,
  input wire logic noexec_seg,
  input wire logic guarded,
  input wire logic prot_denied,
  input wire logic direct_store,
  input wire logic higher_prio_pending,
  output logic redirect_valid,
  output logic [31:0] redirect_addr,
  output logic [31:0] machine_state,
  output logic irq
);
  import fetch_fault_pkg::*;

  // Reset image of the whole unit state
  localparam unit_state_t RST_STATE = '{
    ret: RST_WORD,
    status: RST_WORD,
    mstate: RST_WORD,
    evt: RST_EVT,
    mask: RST_EVT,
    rdata: RST_WORD,
    ack: 1'b0,
    redirect: 1'b0,
    target: RST_WORD,
    irq: 1'b0
  };

  // The three fetch fault cause bits of the saved status word
  localparam logic [31:0] CAUSE_MASK = (32'h1 << POS_CAUSE_MISS) | (32'h1 << POS_CAUSE_STORAGE)
    | (32'h1 << POS_CAUSE_PROT);

  // State word bits that entry leaves as they were
  localparam logic [31:0] KEEP_MASK = (32'h1 << POS_MCHECK) | (32'h1 << POS_VEC_SEL)
    | (32'h1 << POS_HANDLER_ORDER);

  // Registered state and the value it takes at the next edge
  unit_state_t state_reg;
  unit_state_t state_next;

  // Bus request decode
  logic bus_req;
  logic bus_accept;
  logic bus_commit;
  logic bus_write;
  logic bus_read_evt;
  logic [31:0] lane_mask;
  logic [31:0] read_word;

  // Fault capture
  logic fault_take;
  logic [31:0] fault_return;
  logic [31:0] fault_status;
  logic [31:0] fault_mstate;
  logic [31:0] fault_target;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clear;

  // Bundle to the cause classifier, which sits in this clock domain
  fetch_fault_if ffi ();

  // Raw failure flags and the relocation state go to the classifier
  assign ffi.xlate_miss = xlate_miss;
  assign ffi.noexec_seg = noexec_seg;
  assign ffi.guarded = guarded;
  assign ffi.prot_denied = prot_denied;
  assign ffi.direct_store = direct_store;
  assign ffi.relocate_on = state_reg.mstate[POS_IRELOC];

  // Picks one cause class: segment class, then missing translation, then protection
  fetch_fault_classifier classify (
    .ff(ffi)
  );

  // A request is accepted on its first edge and committed on the edge where ack stands
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_accept = bus_req & ~state_reg.ack;
  assign bus_commit = bus_req & state_reg.ack;
  assign bus_write = bus_commit & wb_we_i;
  assign bus_read_evt = bus_commit & ~wb_we_i & (wb_adr_i == OFS_EVENT);

  // Byte lanes of a write
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Read data, sampled on acceptance so it stands through the ack cycle
  always_comb begin
    read_word = 32'h0000_0000;
    case (wb_adr_i)
      OFS_RETURN: begin
        read_word = state_reg.ret;
      end
      OFS_STATUS: begin
        read_word = state_reg.status;
      end
      OFS_MSTATE: begin
        read_word = state_reg.mstate;
      end
      OFS_EVENT: begin
        read_word = {{(32 - EVT_W){1'b0}}, state_reg.evt};
      end
      OFS_MASK: begin
        read_word = {{(32 - EVT_W){1'b0}}, state_reg.mask};
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // Take only a valid failed fetch, with nothing higher waiting and no redirect in flight
  assign fault_take = fetch_valid & ffi.fault & ~higher_prio_pending
    & ~state_reg.redirect;

  // Return point: the branch target when the failing fetch was one, else the next address
  assign fault_return = fetch_branch ? fetch_branch_ea : fetch_next_ea;

  // Saved status: required state bits copied, bits 10-15 and the rest zero, one cause bit
  always_comb begin
    fault_status = state_reg.mstate & COPY_MASK;
    fault_status[POS_CAUSE_MISS] = ffi.cause[EVT_MISS];
    fault_status[POS_CAUSE_STORAGE] = ffi.cause[EVT_STORAGE];
    fault_status[POS_CAUSE_PROT] = ffi.cause[EVT_PROT];
  end

  // New state word: listed bits cleared, byte order taken from the handler order
  always_comb begin
    fault_mstate = state_reg.mstate & ~CLEAR_MASK;
    fault_mstate[POS_BYTE_ORDER] = state_reg.mstate[POS_HANDLER_ORDER];
  end

  // Vector base picked by the select bit, which entry keeps
  assign fault_target = VEC_OFFSET
    | (state_reg.mstate[POS_VEC_SEL] ? VEC_BASE_HIGH : VEC_BASE_LOW);

  // Events set by a taken fault; a read clears only the bits it reported
  assign evt_set = fault_take ? ffi.cause : {EVT_W{1'b0}};
  assign evt_clear = bus_read_evt ? state_reg.rdata[EVT_W-1:0] : {EVT_W{1'b0}};

  // Next state: bus handshake, register writes, then fault entry, which wins over a return, status or state write
  always_comb begin
    state_next = state_reg;
    state_next.ack = bus_accept;
    if (bus_accept && !wb_we_i) begin
      state_next.rdata = read_word;
    end
    if (bus_write) begin
      case (wb_adr_i)
        OFS_RETURN: begin
          state_next.ret = (state_reg.ret & ~lane_mask) | (wb_dat_i & lane_mask);
        end
        OFS_STATUS: begin
          state_next.status = (state_reg.status & ~lane_mask) | (wb_dat_i & lane_mask);
        end
        OFS_MSTATE: begin
          state_next.mstate = (state_reg.mstate & ~lane_mask) | (wb_dat_i & lane_mask);
        end
        OFS_MASK: begin
          if (wb_sel_i[0]) begin
            state_next.mask = wb_dat_i[EVT_W-1:0];
          end
        end
        default: begin
          state_next.mask = state_reg.mask;
        end
      endcase
    end
    // A fault in the same cycle as a return, status or state write replaces what the write put there
    if (fault_take) begin
      state_next.ret = fault_return;
      state_next.status = fault_status;
      state_next.mstate = fault_mstate;
      state_next.target = fault_target;
    end
    state_next.redirect = fault_take;
    // Set wins over a read clear in the same cycle
    state_next.evt = (state_reg.evt & ~evt_clear) | evt_set;
    state_next.irq = |(state_next.evt & state_next.mask);
  end

  // State register; reset loads constants only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RST_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output straight from the state register
  assign wb_dat_o = state_reg.rdata;
  assign wb_ack_o = state_reg.ack;
  assign redirect_valid = state_reg.redirect;
  assign redirect_addr = state_reg.target;
  assign machine_state = state_reg.mstate;
  assign irq = state_reg.irq;

  // Ack stands for exactly one cycle
  ack_single_cycle_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o
  ) else $error("Bus ack held for more than one cycle");

  // Ack only answers a request
  ack_needs_req_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)
  ) else $error("Bus ack without a request");

  // A new request is answered in the next cycle
  ack_answer_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o
  ) else $error("Bus request not answered");

  // A pending higher exception blocks the fault
  redirect_blocked_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    higher_prio_pending |=> !redirect_valid
  ) else $error("Fault taken over a higher exception");

  // Only a presented fetch can fault
  redirect_needs_fetch_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> $past(fetch_valid)
  ) else $error("Fault taken without a fetch");

  // Redirect is a one-cycle pulse
  redirect_single_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |=> !redirect_valid
  ) else $error("Redirect held for more than one cycle");

  // Missing translation raises the fault
  miss_raises_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (fetch_valid && xlate_miss && !higher_prio_pending && !redirect_valid) |=> redirect_valid
  ) else $error("Translation miss did not fault");

  // No-execute segment raises the fault
  noexec_raises_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (fetch_valid && noexec_seg && !higher_prio_pending && !redirect_valid) |=> redirect_valid
  ) else $error("No-execute fetch did not fault");

  // Guarded fetch with relocation on raises the fault
  guarded_raises_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (fetch_valid && guarded && machine_state[POS_IRELOC] && !higher_prio_pending
      && !redirect_valid) |=> redirect_valid
  ) else $error("Guarded fetch did not fault");

  // Protection refusal raises the fault
  prot_raises_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (fetch_valid && prot_denied && !higher_prio_pending && !redirect_valid) |=> redirect_valid
  ) else $error("Protection refusal did not fault");

  // Direct-store segment raises the fault
  direct_raises_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (fetch_valid && direct_store && !higher_prio_pending && !redirect_valid) |=> redirect_valid
  ) else $error("Direct-store fetch did not fault");

  // Return address is the branch target or the next address
  return_addr_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> state_reg.ret == $past(fetch_branch ? fetch_branch_ea : fetch_next_ea)
  ) else $error("Wrong saved return address");

  // Miss cause bit only when no segment class failure
  miss_cause_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> state_reg.status[POS_CAUSE_MISS] == $past(xlate_miss && !(direct_store
      || noexec_seg || (guarded && machine_state[POS_IRELOC])))
  ) else $error("Wrong miss cause bit");

  // Segment class cause bit
  storage_cause_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> state_reg.status[POS_CAUSE_STORAGE] == $past(direct_store || noexec_seg
      || (guarded && machine_state[POS_IRELOC]))
  ) else $error("Wrong segment cause bit");

  // Protection cause bit when nothing else explains the fault
  prot_cause_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> state_reg.status[POS_CAUSE_PROT] == $past(prot_denied && !xlate_miss
      && !(direct_store || noexec_seg || (guarded && machine_state[POS_IRELOC])))
  ) else $error("Wrong protection cause bit");

  // Exactly one cause bit per fault
  one_cause_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> $onehot(state_reg.status & CAUSE_MASK)
  ) else $error("Cause bits not one-hot");

  // Required state bits copied into the saved status
  copy_bits_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> (state_reg.status & COPY_MASK) == ($past(machine_state) & COPY_MASK)
  ) else $error("Saved status copy wrong");

  // Bits 10-15 and all uncopied bits other than the cause bits read zero
  clear_bits_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> (state_reg.status & ~COPY_MASK & ~CAUSE_MASK) == 32'h0000_0000
  ) else $error("Saved status bits not cleared");

  // Listed state bits cleared on entry
  entry_clears_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> (machine_state & CLEAR_MASK & ~(32'h1 << POS_BYTE_ORDER)) == 32'h0000_0000
  ) else $error("State bits not cleared on entry");

  // Check enable, vector select and handler order kept
  entry_keeps_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> (machine_state & KEEP_MASK) == ($past(machine_state) & KEEP_MASK)
  ) else $error("Kept state bits changed on entry");

  // Byte order follows the handler order
  byte_order_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> machine_state[POS_BYTE_ORDER] == $past(machine_state[POS_HANDLER_ORDER])
  ) else $error("Byte order not taken from handler order");

  // Redirect lands on the fault vector
  vector_target_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    redirect_valid |-> redirect_addr == (VEC_OFFSET
      | (machine_state[POS_VEC_SEL] ? VEC_BASE_HIGH : VEC_BASE_LOW))
  ) else $error("Wrong fault vector");
endmodule // fetch_fault_unit
`default_nettype wire

//--- fetch_model.sv
// Fetch path model: one fetch result with one failure flag on request.
// Assumes the bench asks for one fetch at a time.
`timescale 1ns/10ps
`default_nettype none
module fetch_model (input wire logic clk_sys, input wire logic go, input wire logic [2:0] kind,
  input wire logic [31:0] ea, output logic f_valid, output logic [31:0] f_ea,
  output logic [4:0] f_flag);
  // One-cycle result; address inverted while idle
  always_ff @(posedge clk_sys) begin
    f_valid <= go;
    f_ea <= go ? ea : ~f_ea;
    f_flag <= go ? 5'h1 << kind : 5'h0;
  end
endmodule // fetch_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the fetch fault unit.
// Assumes a one-cycle redirect pulse and acks within 20 cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fetch_fault_pkg::*;
  logic clk_sys = 0, rst_n = 0, cyc = 0, we = 0, go = 0, br = 0, hp = 0, fv, ack, rv, irq;
  logic [2:0] kind = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, ea = 0, bea = 0, fea, rdat, raddr, ms, ms_o;
  logic [4:0] fl;
  logic [31:0] q[$];
  int failures = 0, tests_run = 0;
  fetch_model model (.clk_sys, .go, .kind, .ea, .f_valid(fv), .f_ea(fea), .f_flag(fl));
  fetch_fault_unit dut (.clk_sys, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fetch_valid(fv), .fetch_next_ea(fea), .fetch_branch(br), .fetch_branch_ea(bea),
    .xlate_miss(fl[0]), .noexec_seg(fl[1]), .guarded(fl[2]), .prot_denied(fl[3]),
    .direct_store(fl[4]), .higher_prio_pending(hp), .redirect_valid(rv),
    .redirect_addr(raddr), .machine_state(ms_o), .irq);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("Counts: %0d compared, %0d failed", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait on ack or redirect
  task automatic wait_for(input bit on_ack);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if ((on_ack ? ack : rv) === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; we <= w; adr <= a; dat <= d;
    wait_for(1);
    cyc <= 0;
    @(posedge clk_sys);
  endtask
  task automatic fault(input logic [2:0] k, input logic m);
    int c;
    c = k == 0 ? EVT_MISS : k == 3 ? EVT_PROT : EVT_STORAGE;
    ms = $urandom | (32'h1 << POS_IRELOC);
    wb(1, OFS_MSTATE, ms);
    wb(1, OFS_MASK, {29'h0, {3{m}}});
    ea <= $urandom; bea <= $urandom; br <= 1'($urandom); kind <= k;
    @(posedge clk_sys);
    q.push_back(VEC_OFFSET | (ms[POS_VEC_SEL] ? VEC_BASE_HIGH : VEC_BASE_LOW));
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    wait_for(0);
    @(posedge clk_sys);
    chk("state", ms & ~CLEAR_MASK | 32'(ms[POS_HANDLER_ORDER]) << POS_BYTE_ORDER, ms_o);
    chk("irq", {31'h0, m}, {31'h0, irq});
    q.push_back(br ? bea : ea);
    wb(0, OFS_RETURN, 0);
    q.push_back(ms & COPY_MASK | 32'h1 << (c == EVT_MISS ? POS_CAUSE_MISS : c == EVT_PROT ?
      POS_CAUSE_PROT : POS_CAUSE_STORAGE));
    wb(0, OFS_STATUS, 0);
    q.push_back(32'h1 << c);
    wb(0, OFS_EVENT, 0);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("Test cause %0d done", k);
  endtask
  // Clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // Reads and redirects compared with the oldest note
  always @(posedge clk_sys) begin
    if (rv === 1'b1 && q.size() > 0) chk("redirect", q.pop_front(), raddr);
    if (ack === 1'b1 && !we && q.size() > 0) chk("read", q.pop_front(), rdat);
  end
  // Main sequence
  initial begin
    int hits;
    void'($urandom(32'h5ab8));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    q.push_back(32'h0000_0000);
    wb(0, 8'h20, 0);
    for (int k = 0; k < 5; k++) fault(k[2:0], k[0]);
    hp <= 1; go <= 1; hits = 0;
    @(posedge clk_sys);
    go <= 0;
    repeat (10) begin
      @(posedge clk_sys);
      hits += (rv === 1'b1);
    end
    chk("blocked", 0, hits);
    $display("Test pending done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
